// >>> logic/tcsa_attach.sv
// Type-C source attach, accessory, polarity, sleep and supply-select logic
`timescale 1ns/1ps
`default_nettype none
`include "tcsa_consts.svh"
module tcsa_attach #(
  parameter int unsigned DEB_CYC = `TCSA_DEB_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_cc1_above_lower,
  input wire logic i_cc1_above_upper,
  input wire logic i_cc2_above_lower,
  input wire logic i_cc2_above_upper,
  input wire logic i_vbus_below_fall,
  input wire logic i_vbus_above_uvlo,
  input wire logic i_dangle_cable,
  input wire logic [1:0] i_contract_volt,
  input wire logic i_contract_valid,
  input wire logic i_gate_req,
  output logic o_sink_attached_n_oe,
  output logic o_audio_n_oe,
  output logic o_debug_n_oe,
  output logic o_cable_flip_n_oe,
  output logic o_logic_supply_out,
  output logic o_logic_supply_out_oe,
  output logic o_supply_sel_high_oe,
  output logic o_supply_sel_low_oe,
  output logic o_main_gate_drive,
  output logic o_sleep
);
  // ----------------------------------------
  // Condition decode and debounce
  // ----------------------------------------
  localparam int NC = 6;
  logic [NC-1:0] raw; // Raw conditions to debounce
  logic [NC-1:0] stb; // Debounced-true levels
  logic [5:0] pin; // Pin-side comparator inputs
  logic [5:0] pin_s; // Their synchronised copies
  // Pin levels with nothing plugged in and VBUS absent
  localparam logic [5:0] PIN_IDLE = 6'h1f;
  logic cc1_win;
  logic cc2_win;
  logic cc1_low;
  logic cc2_low;
  logic vbus_low;
  logic dangle;

  assign pin = {i_dangle_cable, i_vbus_below_fall, i_cc2_above_upper,
                i_cc2_above_lower, i_cc1_above_upper, i_cc1_above_lower};

  // Synchronise every comparator before use
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_pin
      tcsa_debounce #(.DEB_CYC(1), .RST_LEVEL(PIN_IDLE[g])) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_level(pin[g]),
        .o_sync(pin_s[g]),
        .o_stable()
      );
    end
  endgenerate

  assign cc1_win = pin_s[0] && !pin_s[1];
  assign cc2_win = pin_s[2] && !pin_s[3];
  assign cc1_low = !pin_s[0];
  assign cc2_low = !pin_s[2];
  assign vbus_low = pin_s[4];
  assign dangle = pin_s[5];

  // Conditions: sink, sink absent, audio on, audio off, debug on, dangle
  assign raw[0] = (cc1_win ^ cc2_win) && vbus_low;
  assign raw[1] = !(cc1_win ^ cc2_win);
  assign raw[2] = cc1_low && cc2_low;
  assign raw[3] = !(cc1_low && cc2_low);
  assign raw[4] = cc1_win && cc2_win;
  assign raw[5] = dangle;

  // Debounce each condition over the attach time
  generate
    for (g = 0; g < NC; g++) begin : g_deb
      tcsa_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_level(raw[g]),
        .o_sync(),
        .o_stable(stb[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Attach state
  // ----------------------------------------
  tcsa_pkg::tcsa_attach_e st_q;
  tcsa_pkg::tcsa_attach_e st_d;
  logic flip_q;

  // Next attach state from debounced conditions and the live debug window
  always_comb begin
    st_d = st_q;
    case (st_q)
      tcsa_pkg::TCSA_OPEN, tcsa_pkg::TCSA_DANGLE: begin
        if (stb[0]) begin
          st_d = tcsa_pkg::TCSA_SINK;
        end else if (stb[2]) begin
          st_d = tcsa_pkg::TCSA_AUDIO;
        end else if (stb[4] && raw[4]) begin
          // Live window check stops a bounce back in just after release
          st_d = tcsa_pkg::TCSA_DEBUG;
        end else if (stb[5]) begin
          st_d = tcsa_pkg::TCSA_DANGLE;
        end else begin
          st_d = tcsa_pkg::TCSA_OPEN;
        end
      end
      tcsa_pkg::TCSA_SINK: begin
        // Hold until the sink has been gone for the debounce time
        if (stb[1]) begin
          st_d = tcsa_pkg::TCSA_OPEN;
        end
      end
      tcsa_pkg::TCSA_AUDIO: begin
        // Release after a CC line stays above the lower threshold
        if (stb[3]) begin
          st_d = tcsa_pkg::TCSA_OPEN;
        end
      end
      tcsa_pkg::TCSA_DEBUG: begin
        // Release as soon as either line leaves the window
        if (!raw[4]) begin
          st_d = tcsa_pkg::TCSA_OPEN;
        end
      end
      default: begin
        st_d = tcsa_pkg::TCSA_OPEN;
      end
    endcase
  end

  // Attach state register
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_q <= tcsa_pkg::TCSA_OPEN;
    end else begin
      st_q <= st_d;
    end
  end

  // Orientation latched on sink attach
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      flip_q <= 1'b0;
    end else if (st_d == tcsa_pkg::TCSA_SINK && st_q != tcsa_pkg::TCSA_SINK) begin
      flip_q <= cc2_win;
    end
  end

  // ----------------------------------------
  // Indicators
  // ----------------------------------------
  // Open-drain indicators: enable high means pulled low
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_sink_attached_n_oe <= 1'b0;
      o_audio_n_oe <= 1'b0;
      o_debug_n_oe <= 1'b0;
      o_cable_flip_n_oe <= 1'b0;
      o_logic_supply_out <= 1'b0;
      o_logic_supply_out_oe <= 1'b0;
    end else begin
      o_sink_attached_n_oe <= (st_d == tcsa_pkg::TCSA_SINK);
      o_audio_n_oe <= (st_d == tcsa_pkg::TCSA_AUDIO);
      o_debug_n_oe <= (st_d == tcsa_pkg::TCSA_DEBUG);
      o_cable_flip_n_oe <= (st_d == tcsa_pkg::TCSA_SINK) &&
        ((st_q == tcsa_pkg::TCSA_SINK) ? flip_q : cc2_win);
      o_logic_supply_out <= (st_d == tcsa_pkg::TCSA_SINK) || (st_d == tcsa_pkg::TCSA_AUDIO) ||
        (st_d == tcsa_pkg::TCSA_DEBUG);
      o_logic_supply_out_oe <= (st_d == tcsa_pkg::TCSA_SINK) || (st_d == tcsa_pkg::TCSA_AUDIO) ||
        (st_d == tcsa_pkg::TCSA_DEBUG);
    end
  end

  // ----------------------------------------
  // Sleep
  // ----------------------------------------
  // Asleep while open or dangling; any state change wakes for a cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_sleep <= 1'b0;
    end else if (st_d != st_q) begin
      o_sleep <= 1'b0;
    end else begin
      o_sleep <= (st_q == tcsa_pkg::TCSA_OPEN) || (st_q == tcsa_pkg::TCSA_DANGLE);
    end
  end

  // ----------------------------------------
  // Supply select
  // ----------------------------------------
  // Follow accepted contract while a sink is attached, else 5 V
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || st_q != tcsa_pkg::TCSA_SINK) begin
      o_supply_sel_low_oe <= 1'b0;
      o_supply_sel_high_oe <= 1'b0;
    end else if (i_contract_valid) begin
      o_supply_sel_low_oe <= (i_contract_volt != `TCSA_V_LOW);
      o_supply_sel_high_oe <= (i_contract_volt == `TCSA_V_HIGH);
    end
  end

  // ----------------------------------------
  // Gate block at power-up
  // ----------------------------------------
  logic chk_q; // Power-up check done
  logic blk_q; // Gate blocked
  // Sample synchronised VBUS-above-UVLO once after reset
  logic [2:0] uv_q;
  logic [1:0] fill_q; // Edges since reset, saturating at three
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      uv_q <= 3'h0;
      fill_q <= 2'h0;
      chk_q <= 1'b0;
      blk_q <= 1'b0;
    end else begin
      uv_q <= {uv_q[1:0], i_vbus_above_uvlo};
      if (fill_q != 2'h3) begin
        fill_q <= fill_q + 2'h1;
      end
      // Decide only once all three stages hold real pin samples
      if (!chk_q && fill_q == 2'h3 && uv_q[2] == uv_q[1]) begin
        chk_q <= 1'b1;
        blk_q <= uv_q[2];
      end
    end
  end

  // Gate drive only with a sink attached, the check passed and a request
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_main_gate_drive <= 1'b0;
    end else begin
      o_main_gate_drive <= chk_q && !blk_q && i_gate_req &&
        (st_d == tcsa_pkg::TCSA_SINK);
    end
  end
endmodule // tcsa_attach
`default_nettype wire

// >>> logic/tcsa_consts.svh
// Constants for the Type-C source attach indicator block
`ifndef TCSA_CONSTS_SVH
`define TCSA_CONSTS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define TCSA_CLK_HZ 10000000
`define TCSA_DEB_US 150
`define TCSA_DEB_CYC ((`TCSA_DEB_US * (`TCSA_CLK_HZ / 1000000)))

// ----------------------------------------
// Contract voltage codes
// ----------------------------------------
`define TCSA_V_LOW 2'h0
`define TCSA_V_MID 2'h1
`define TCSA_V_HIGH 2'h2

`endif

// >>> logic/tcsa_pkg.sv
// Types for the Type-C source attach indicator block
`default_nettype none
package tcsa_pkg;
  // Debounced attach state
  typedef enum logic [2:0] {
    TCSA_OPEN,
    TCSA_SINK,
    TCSA_AUDIO,
    TCSA_DEBUG,
    TCSA_DANGLE
  } tcsa_attach_e;
endpackage
`default_nettype wire

// >>> logic/tcsa_debounce.sv
// Three-stage synchroniser plus debounce counter for one level
`timescale 1ns/1ps
`default_nettype none
module tcsa_debounce #(
  parameter int unsigned DEB_CYC = 1500,
  parameter logic RST_LEVEL = 1'b0 // Idle level of the input, loaded at reset
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_level,
  output logic o_sync,
  output logic o_stable
);
  // ----------------------------------------
  // Synchroniser
  // ----------------------------------------
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic [31:0] cnt_q;

  // Three flops; first stage feeds only the second
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      // Start at the idle level so no false change follows reset
      s1_q <= RST_LEVEL;
      s2_q <= RST_LEVEL;
      s3_q <= RST_LEVEL;
    end else begin
      s1_q <= i_level;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Synchronised level counts once stages two and three agree
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_sync <= RST_LEVEL;
    end else if (s2_q == s3_q) begin
      o_sync <= s3_q;
    end
  end

  // ----------------------------------------
  // Debounce
  // ----------------------------------------
  // Count cycles the level has held high; stable once terminal count reached
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cnt_q <= 32'h0;
      o_stable <= 1'b0;
    end else if (!o_sync) begin
      cnt_q <= 32'h0;
      o_stable <= 1'b0;
    end else if (cnt_q >= DEB_CYC - 1) begin
      o_stable <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
endmodule // tcsa_debounce
`default_nettype wire

// >>> test/tcsa_cc_partner.sv
// Behavioural model of a sink or accessory seen through the CC comparators
`timescale 1ns/1ps
`default_nettype none
module tcsa_cc_partner (
  input wire logic [2:0] i_kind,
  output logic o_cc1_above_lower,
  output logic o_cc1_above_upper,
  output logic o_cc2_above_lower,
  output logic o_cc2_above_upper,
  output logic o_dangle_cable
);
  // ----------------------------------------
  // Termination kinds
  // ----------------------------------------
  // Comparator levels per kind: cc1 lower, cc1 upper, cc2 lower, cc2 upper, dangle flag
  always_comb begin
    case (i_kind)
      3'h1: {o_cc1_above_lower, o_cc1_above_upper, o_cc2_above_lower, o_cc2_above_upper, o_dangle_cable} = 5'h16;
      3'h2: {o_cc1_above_lower, o_cc1_above_upper, o_cc2_above_lower, o_cc2_above_upper, o_dangle_cable} = 5'h1c;
      3'h3: {o_cc1_above_lower, o_cc1_above_upper, o_cc2_above_lower, o_cc2_above_upper, o_dangle_cable} = 5'h00;
      3'h4: {o_cc1_above_lower, o_cc1_above_upper, o_cc2_above_lower, o_cc2_above_upper, o_dangle_cable} = 5'h14;
      3'h5: {o_cc1_above_lower, o_cc1_above_upper, o_cc2_above_lower, o_cc2_above_upper, o_dangle_cable} = 5'h07;
      // Nothing attached: both lines float above the upper threshold
      default: {o_cc1_above_lower, o_cc1_above_upper, o_cc2_above_lower, o_cc2_above_upper, o_dangle_cable} = 5'h1e;
    endcase
  end
endmodule // tcsa_cc_partner
`default_nettype wire

// >>> test/tcsa_attach_checker.sv
// Concurrent checks on the ports of the attach block
`timescale 1ns/1ps
`default_nettype none
module tcsa_attach_checker (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_cc1_above_upper,
  input wire logic i_cc2_above_upper,
  input wire logic [1:0] i_contract_volt,
  input wire logic i_contract_valid,
  input wire logic i_gate_req,
  input wire logic o_sink_attached_n_oe,
  input wire logic o_audio_n_oe,
  input wire logic o_debug_n_oe,
  input wire logic o_cable_flip_n_oe,
  input wire logic o_logic_supply_out,
  input wire logic o_logic_supply_out_oe,
  input wire logic o_supply_sel_high_oe,
  input wire logic o_supply_sel_low_oe,
  input wire logic o_main_gate_drive,
  input wire logic o_sleep
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sel_order_a: assert property (o_supply_sel_high_oe |-> o_supply_sel_low_oe) else $error("high select without low");
  sel_load_a: assert property (i_contract_valid && o_sink_attached_n_oe && i_contract_volt == 2'h2 |=>
    o_supply_sel_high_oe && o_supply_sel_low_oe) else $error("high contract not loaded");
  sel_clear_a: assert property ((!o_sink_attached_n_oe)[*2] |-> !o_supply_sel_low_oe) else $error("select while detached");
  supply_on_a: assert property (o_sink_attached_n_oe || o_audio_n_oe || o_debug_n_oe |->
    o_logic_supply_out && o_logic_supply_out_oe) else $error("logic supply off while attached");
  flip_sink_a: assert property (o_cable_flip_n_oe |-> o_sink_attached_n_oe) else $error("flip without sink");
  sleep_idle_a: assert property (o_sleep |-> !o_logic_supply_out_oe) else $error("asleep while attached");
  debug_drop_a: assert property (($rose(i_cc1_above_upper) || $rose(i_cc2_above_upper)) && o_debug_n_oe
    |-> ##[1:8] !o_debug_n_oe) else $error("debug not released");
  gate_cause_a: assert property (o_main_gate_drive |-> $past(i_gate_req) && o_sink_attached_n_oe) else $error("gate on");
  reset_quiet_a: assert property ($past(i_rst) |-> !(o_sink_attached_n_oe || o_audio_n_oe || o_debug_n_oe
    || o_logic_supply_out_oe || o_supply_sel_low_oe || o_main_gate_drive)) else $error("output after reset");
endmodule // tcsa_attach_checker
bind tcsa_attach tcsa_attach_checker tcsa_attach_checker_i (.i_sys_clk, .i_rst, .i_cc1_above_upper, .i_cc2_above_upper,
  .i_contract_volt, .i_contract_valid, .i_gate_req, .o_sink_attached_n_oe, .o_audio_n_oe, .o_debug_n_oe,
  .o_cable_flip_n_oe, .o_logic_supply_out, .o_logic_supply_out_oe, .o_supply_sel_high_oe, .o_supply_sel_low_oe,
  .o_main_gate_drive, .o_sleep);
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking testbench for the attach block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int DEB = 6; // Short debounce count for simulation
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_vbus_below_fall = 1'b1;
  logic i_vbus_above_uvlo = 1'b0;
  logic [1:0] i_contract_volt = 2'h0;
  logic i_contract_valid = 1'b0;
  logic i_gate_req = 1'b0;
  logic [2:0] kind = 3'h0; // Termination presented by the partner
  logic i_cc1_above_lower, i_cc1_above_upper, i_cc2_above_lower, i_cc2_above_upper, i_dangle_cable;
  logic o_sink_attached_n_oe, o_audio_n_oe, o_debug_n_oe, o_cable_flip_n_oe, o_logic_supply_out;
  logic o_logic_supply_out_oe, o_supply_sel_high_oe, o_supply_sel_low_oe, o_main_gate_drive, o_sleep;
  int miscompares = 0;
  int checked = 0;
  always #50 i_sys_clk = ~i_sys_clk;
  tcsa_cc_partner tcsa_cc_partner_i (.i_kind(kind), .o_cc1_above_lower(i_cc1_above_lower),
    .o_cc1_above_upper(i_cc1_above_upper), .o_cc2_above_lower(i_cc2_above_lower),
    .o_cc2_above_upper(i_cc2_above_upper), .o_dangle_cable(i_dangle_cable));
  tcsa_attach #(.DEB_CYC(DEB)) tcsa_attach_i (.i_sys_clk, .i_rst, .i_cc1_above_lower, .i_cc1_above_upper,
    .i_cc2_above_lower, .i_cc2_above_upper, .i_vbus_below_fall, .i_vbus_above_uvlo, .i_dangle_cable,
    .i_contract_volt, .i_contract_valid, .i_gate_req, .o_sink_attached_n_oe, .o_audio_n_oe, .o_debug_n_oe,
    .o_cable_flip_n_oe, .o_logic_supply_out, .o_logic_supply_out_oe, .o_supply_sel_high_oe,
    .o_supply_sel_low_oe, .o_main_gate_drive, .o_sleep);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %b expected %b", $time, seen, exp);
    end
  endtask
  // Let n edges pass, then settle just after the last one
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic put(input logic [2:0] k);
    @(posedge i_sys_clk);
    kind <= k;
    #1;
  endtask
  function automatic logic pick(input int idx);
    case (idx)
      0: return o_sink_attached_n_oe;
      1: return o_audio_n_oe;
      2: return o_debug_n_oe;
      default: return o_sleep;
    endcase
  endfunction
  // Bounded wait for one indicator to reach a level
  task automatic wait_out(input int idx, input logic val);
    int n;
    n = 0;
    while (pick(idx) !== val && n < 60) begin
      cyc(1);
      n++;
    end
    if (pick(idx) !== val) begin
      miscompares++;
      $display("ERROR at %0t: wait on output %0d ran out", $time, idx);
      close_out();
    end
  endtask
  task automatic do_reset(input logic uvlo);
    @(posedge i_sys_clk);
    i_rst <= 1'b1;
    i_vbus_above_uvlo <= uvlo;
    kind <= 3'h0;
    cyc(4);
    @(posedge i_sys_clk);
    i_rst <= 1'b0;
    cyc(1);
    // Everything released; with nothing attached sleep is entered at once
    chk({o_sink_attached_n_oe, o_audio_n_oe, o_debug_n_oe, o_cable_flip_n_oe, o_logic_supply_out,
      o_logic_supply_out_oe, o_supply_sel_high_oe, o_supply_sel_low_oe, o_main_gate_drive, o_sleep}, 10'h001);
    cyc(4);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_gate_block();
    put(3'h1);
    wait_out(0, 1'b1);
    cyc(5);
    chk(o_main_gate_drive, 0);
    $display("gate block test done");
  endtask
  task automatic t_vbus_high();
    @(posedge i_sys_clk);
    i_vbus_below_fall <= 1'b0;
    kind <= 3'h1;
    cyc(DEB * 3);
    chk(o_sink_attached_n_oe, 0);
    @(posedge i_sys_clk);
    kind <= 3'h0;
    i_vbus_below_fall <= 1'b1;
    wait_out(3, 1'b1);
    $display("vbus high test done");
  endtask
  task automatic t_sink(input logic [2:0] k);
    put(k);
    wait_out(0, 1'b1);
    chk({o_cable_flip_n_oe, o_logic_supply_out, o_logic_supply_out_oe, o_sleep}, {k == 3'h2, 3'b110});
    cyc(2);
    chk(o_main_gate_drive, 1);
    for (int v = 0; v < 3; v++) begin
      @(posedge i_sys_clk);
      i_contract_volt <= v[1:0];
      i_contract_valid <= 1'b1;
      @(posedge i_sys_clk);
      i_contract_valid <= 1'b0;
      cyc(1);
      chk({o_supply_sel_high_oe, o_supply_sel_low_oe}, {v == 2, v != 0});
    end
    put(3'h0);
    cyc(2);
    put(k);
    cyc(DEB + 6);
    chk(o_sink_attached_n_oe, 1);
    put(3'h0);
    cyc(DEB);
    chk(o_sink_attached_n_oe, 1);
    wait_out(0, 1'b0);
    // Selects clear one edge after the indicator drops
    cyc(1);
    chk({o_supply_sel_high_oe, o_supply_sel_low_oe, o_cable_flip_n_oe}, 3'h0);
    wait_out(3, 1'b1);
    $display("sink test done");
  endtask
  task automatic t_audio();
    put(3'h3);
    wait_out(1, 1'b1);
    chk(o_logic_supply_out_oe, 1);
    put(3'h0);
    cyc(2);
    put(3'h3);
    cyc(DEB + 6);
    chk(o_audio_n_oe, 1);
    put(3'h0);
    cyc(DEB);
    chk(o_audio_n_oe, 1);
    wait_out(1, 1'b0);
    $display("audio test done");
  endtask
  task automatic t_debug();
    put(3'h4);
    wait_out(2, 1'b1);
    // Both lines leave the window; release must beat the debounce time
    put(3'h0);
    cyc(8);
    chk(o_debug_n_oe, 0);
    wait_out(3, 1'b1);
    $display("debug test done");
  endtask
  task automatic t_dangle();
    put(3'h5);
    cyc(DEB * 3);
    chk({o_sleep, o_logic_supply_out_oe}, 2'b10);
    put(3'h2);
    wait_out(0, 1'b1);
    chk(o_sleep, 0);
    $display("dangle test done");
  endtask
  initial begin
    do_reset(1'b1);
    @(posedge i_sys_clk);
    i_gate_req <= 1'b1;
    t_gate_block();
    do_reset(1'b0);
    t_vbus_high();
    t_sink(3'h1);
    t_sink(3'h2);
    t_audio();
    t_debug();
    t_dangle();
    close_out();
  end
endmodule // tb_top
`default_nettype wire
